// File: fan_pkg.sv
package fan_pkg;

  // ==========================================================================
  // Core timing.
  localparam int unsigned CLK_HZ         = 125000000;
  localparam int unsigned PWM_HZ         = 30;
  // PWM period in core clocks, rounded down; a parameter default in the top.
  localparam int unsigned PWM_PERIOD_CLK = CLK_HZ / PWM_HZ;

  // ==========================================================================
  // Sequencer counter width in bits, then counts in PWM cycles.
  localparam int unsigned CNT_W          = 6;
  localparam logic [5:0]  BOOST_CYCLES   = 6'h20;
  localparam logic [5:0]  DIAG_CYCLES    = 6'h03;
  localparam logic [5:0]  MISS_CYCLES    = 6'h20;

  // ==========================================================================
  // Duty command width; full scale means 100% on.
  localparam int unsigned DUTY_W         = 8;

  // ==========================================================================
  // Sequencer states.
  typedef enum logic [2:0] {
    ST_OFF    = 3'h0,
    ST_BOOST1 = 3'h1,
    ST_BOOST2 = 3'h2,
    ST_NORMAL = 3'h3,
    ST_DIAG   = 3'h4,
    ST_RETRY  = 3'h5,
    ST_FAULT  = 3'h6
  } seq_state_t;

endpackage

// File: fan_if.sv
`timescale 1ns/1ps

// ============================================================================
// Link between the PWM time base and the sequencer.
interface fan_if;
  logic cycle_start;
  logic pwm_on;

  modport timebase (output cycle_start, output pwm_on);
  modport seq      (input cycle_start, input pwm_on);
endinterface

// File: fan_pwm_timebase.sv
`timescale 1ns/1ps

// ============================================================================
// PWM ramp counter and comparator.
module fan_pwm_timebase #(
  parameter int unsigned PERIOD_CLK = fan_pkg::PWM_PERIOD_CLK,
  parameter int unsigned DUTY_W     = fan_pkg::DUTY_W
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_run,
  input  wire logic [DUTY_W-1:0] i_duty,
  fan_if.timebase                tb
);
  localparam int unsigned CW = $clog2(PERIOD_CLK + 1);
  localparam logic [CW-1:0] LAST = CW'(PERIOD_CLK - 1);
  localparam logic [DUTY_W-1:0] FULL = '1;

  logic [CW-1:0] ramp_q;
  logic [CW-1:0] ramp_d;
  logic [CW+DUTY_W-1:0] thr;

  // Threshold scales duty to the period; full-scale duty means always on.
  always_comb begin
    thr    = (CW+DUTY_W)'(i_duty) * (CW+DUTY_W)'(PERIOD_CLK);
    ramp_d = (ramp_q == LAST || !i_run) ? '0 : ramp_q + 1'b1;
    tb.cycle_start = i_run && (ramp_q == '0);
    tb.pwm_on = i_run && ((i_duty == FULL) ||
                ((CW+DUTY_W)'(ramp_q) * (CW+DUTY_W)'(FULL) < thr));
  end

  // The ramp restarts from zero whenever running resumes.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ramp_q <= '0;
    end else begin
      ramp_q <= ramp_d;
    end
  end
endmodule

// File: fan_pwm_fault_sequencer.sv
`timescale 1ns/1ps

module fan_pwm_fault_sequencer #(
  parameter int unsigned PERIOD_CLK = fan_pkg::PWM_PERIOD_CLK,
  parameter int unsigned DUTY_W     = fan_pkg::DUTY_W,
  parameter int unsigned BLANK_CLK  = 16
) (
  // Clock and reset.
  input  wire logic              i_core_clk,
  input  wire logic              i_nrst,
  // Commands.
  input  wire logic [DUTY_W-1:0] i_temp_duty,
  input  wire logic [DUTY_W-1:0] i_min_duty,
  input  wire logic              i_shutdown,
  // Fan side.
  input  wire logic              i_sense,
  output logic                   o_fan_drive,
  output logic                   o_fault_n
);
  // ==========================================================================
  // Reset release.
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ==========================================================================
  // Sense synchroniser, edge detector and turn-on blanking.
  localparam int unsigned BW = $clog2(BLANK_CLK + 1);
  logic [2:0]    sense_q;
  logic [2:0]    sense_d;
  logic [BW-1:0] blank_q;
  logic [BW-1:0] blank_d;
  logic          pwm_on_q;  // Fan output one clock earlier.
  logic          pulse;
  fan_if         lnk ();

  // Only the second and third stages feed the edge detector. Blanking starts when the
  // fan output itself rises, so a boost at zero duty cannot mistake its own turn-on
  // spike for a commutation pulse.
  always_comb begin
    sense_d = {sense_q[1:0], i_sense};
    pulse   = sense_q[1] && !sense_q[2] && (blank_q == '0);
    if (o_fan_drive && !pwm_on_q) begin
      blank_d = BW'(BLANK_CLK);
    end else if (blank_q != '0) begin
      blank_d = blank_q - 1'b1;
    end else begin
      blank_d = blank_q;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sense_q  <= 3'h0;
      blank_q  <= '0;
      pwm_on_q <= 1'b0;
    end else begin
      sense_q  <= sense_d;
      blank_q  <= blank_d;
      pwm_on_q <= o_fan_drive;
    end
  end

  // ==========================================================================
  // PWM time base.
  logic [DUTY_W-1:0] duty;
  logic              run;
  fan_pkg::seq_state_t st_q;
  fan_pkg::seq_state_t st_d;

  always_comb begin
    duty = (i_temp_duty > i_min_duty) ? i_temp_duty : i_min_duty;
    run  = !i_shutdown && (st_q != fan_pkg::ST_FAULT);
  end

  fan_pwm_timebase #(
    .PERIOD_CLK (PERIOD_CLK),
    .DUTY_W     (DUTY_W)
  ) u_timebase (
    .i_clk   (i_core_clk),
    .i_rst_n (rst_n),
    .i_run   (run),
    .i_duty  (duty),
    .tb      (lnk.timebase)
  );

  // ==========================================================================
  // Sequencer. Pulses are latched per PWM cycle; counters advance only at
  // cycle starts, so the PWM period is the sole time base.
  logic [fan_pkg::CNT_W-1:0] cnt_q;
  logic [fan_pkg::CNT_W-1:0] cnt_d;
  logic                      seen_q;
  logic                      seen_d;
  logic                      drive_d;
  logic                      fault_n_d;
  logic                      tick;
  logic                      got;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    tick   = lnk.cycle_start;
    got    = seen_q || pulse;
    seen_d = tick ? 1'b0 : got;
    if (i_shutdown) begin
      st_d   = fan_pkg::ST_OFF;
      cnt_d  = '0;
      seen_d = 1'b0;
    end else begin
      case (st_q)
        fan_pkg::ST_OFF: begin
          st_d  = fan_pkg::ST_BOOST1;
          cnt_d = '0;
        end
        fan_pkg::ST_BOOST1, fan_pkg::ST_BOOST2, fan_pkg::ST_RETRY: begin
          if (got) begin
            st_d   = fan_pkg::ST_NORMAL;
            cnt_d  = '0;
            seen_d = 1'b0;
          end else if (tick) begin
            if (cnt_q == fan_pkg::BOOST_CYCLES - 6'h01) begin
              cnt_d = '0;
              case (st_q)
                fan_pkg::ST_BOOST1: st_d = fan_pkg::ST_BOOST2;
                default:            st_d = fan_pkg::ST_FAULT;
              endcase
            end else begin
              cnt_d = cnt_q + 6'h01;
            end
          end
        end
        fan_pkg::ST_NORMAL: begin
          if (pulse) begin
            cnt_d = '0;
          end else if (tick) begin
            if (cnt_q == fan_pkg::MISS_CYCLES - 6'h01) begin
              st_d  = fan_pkg::ST_DIAG;
              cnt_d = '0;
            end else begin
              cnt_d = cnt_q + 6'h01;
            end
          end
          seen_d = 1'b0;
        end
        fan_pkg::ST_DIAG: begin
          if (got) begin
            st_d   = fan_pkg::ST_NORMAL;
            cnt_d  = '0;
            seen_d = 1'b0;
          end else if (tick) begin
            if (cnt_q == fan_pkg::DIAG_CYCLES - 6'h01) begin
              st_d  = fan_pkg::ST_RETRY;
              cnt_d = '0;
            end else begin
              cnt_d = cnt_q + 6'h01;
            end
          end
        end
        fan_pkg::ST_FAULT: begin
          st_d = fan_pkg::ST_FAULT;
        end
        default: begin
          st_d  = fan_pkg::ST_OFF;
          cnt_d = '0;
        end
      endcase
    end
    // Shutdown wins over everything, then boost phases force full on.
    if (i_shutdown || st_d == fan_pkg::ST_FAULT || st_d == fan_pkg::ST_OFF) begin
      drive_d = 1'b0;
    end else if (st_d == fan_pkg::ST_NORMAL) begin
      drive_d = lnk.pwm_on;
    end else begin
      drive_d = 1'b1;
    end
    fault_n_d = i_shutdown || (st_d != fan_pkg::ST_FAULT);
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q        <= fan_pkg::ST_OFF;
      cnt_q       <= '0;
      seen_q      <= 1'b0;
      o_fan_drive <= 1'b0;
      o_fault_n   <= 1'b1;
    end else begin
      st_q        <= st_d;
      cnt_q       <= cnt_d;
      seen_q      <= seen_d;
      o_fan_drive <= drive_d;
      o_fault_n   <= fault_n_d;
    end
  end

  // ==========================================================================
  // Checks.
  sequence s_shut;
    i_shutdown;
  endsequence

  a_shut_drive_off: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    s_shut |=> !o_fan_drive) else $error("Fan driven during shutdown.");
  a_shut_fault_rel: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    s_shut |=> o_fault_n) else $error("Fault flag low during shutdown.");
  a_fault_latched: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (st_q == fan_pkg::ST_FAULT && !i_shutdown) |=> (!o_fault_n && !o_fan_drive))
    else $error("Fault state not held.");
  a_shut_resets: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    s_shut |=> st_q == fan_pkg::ST_OFF) else $error("Shutdown left state.");
  a_release_boost: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    $fell(i_shutdown) |=> (st_q == fan_pkg::ST_BOOST1 && o_fan_drive))
    else $error("No boost after release.");
  a_boost_full_on: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (st_q == fan_pkg::ST_BOOST1 && !i_shutdown && !got) |=> o_fan_drive)
    else $error("Boost not full on.");
  a_pulse_restarts: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (st_q == fan_pkg::ST_NORMAL && pulse && !i_shutdown) |=> cnt_q == '0)
    else $error("Pulse did not restart count.");
  a_miss_to_diag: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (st_q == fan_pkg::ST_NORMAL && tick && !pulse && !i_shutdown &&
     cnt_q == fan_pkg::MISS_CYCLES - 6'h01) |=> st_q == fan_pkg::ST_DIAG)
    else $error("Missed timeout.");
  a_blank_ignored: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (st_q == fan_pkg::ST_NORMAL && sense_q[1] && !sense_q[2] && blank_q != '0 &&
     !tick && !i_shutdown) |=> $stable(cnt_q)) else $error("Pulse not blanked.");
  a_fault_entry: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (st_q == fan_pkg::ST_RETRY && tick && !got && !i_shutdown &&
     cnt_q == fan_pkg::BOOST_CYCLES - 6'h01) |=> !o_fault_n)
    else $error("Fault not flagged.");

  // ==========================================================================
  // Supervision chain checks. Each phase is named by its last cycle, so a
  // property reads as one step of the chain.
  sequence s_boost2_last;
    st_q == fan_pkg::ST_BOOST2 && tick && !got && !i_shutdown &&
    cnt_q == fan_pkg::BOOST_CYCLES - 6'h01;
  endsequence

  sequence s_diag_last;
    st_q == fan_pkg::ST_DIAG && tick && !got && !i_shutdown &&
    cnt_q == fan_pkg::DIAG_CYCLES - 6'h01;
  endsequence

  sequence s_sense_rise;
    !i_sense ##1 i_sense;
  endsequence

  // A pulse in any boost hands over to normal running with a fresh count.
  a_boost_to_normal: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    ((st_q == fan_pkg::ST_BOOST1 || st_q == fan_pkg::ST_BOOST2 ||
      st_q == fan_pkg::ST_RETRY) && got && !i_shutdown) |=>
    (st_q == fan_pkg::ST_NORMAL && cnt_q == '0)) else $error("Pulse in boost ignored.");
  a_boost2_fault: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    s_boost2_last |=> (st_q == fan_pkg::ST_FAULT && !o_fault_n && !o_fan_drive))
    else $error("Second boost did not fault.");
  a_diag_full_on: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (st_q == fan_pkg::ST_DIAG && !got && !i_shutdown) |=> o_fan_drive)
    else $error("Diagnostic not full on.");
  a_diag_to_retry: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    s_diag_last |=> (st_q == fan_pkg::ST_RETRY && cnt_q == '0 && o_fan_drive))
    else $error("Diagnostic did not retry.");
  a_retry_full_on: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (st_q == fan_pkg::ST_RETRY && !got && !tick && !i_shutdown) |=> o_fan_drive)
    else $error("Retry boost not full on.");

  // Normal running follows the comparator; counters move only on cycle starts or pulses.
  a_normal_follows: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (st_q == fan_pkg::ST_NORMAL && !tick && !i_shutdown) |=>
    (o_fan_drive == $past(lnk.pwm_on))) else $error("Drive does not follow PWM.");
  a_count_on_tick: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (st_q != fan_pkg::ST_OFF && !tick && !got && !i_shutdown) |=> $stable(cnt_q))
    else $error("Counter moved off a PWM cycle start.");

  // The turn-on spike is blanked, and every sense edge outside the blanking window counts exactly once.
  a_blank_on_rise: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    $rose(o_fan_drive) |=> (blank_q == BW'(BLANK_CLK)))
    else $error("Turn-on not blanked.");
  a_sense_edge: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (s_sense_rise ##2 (blank_q == '0)) |-> (pulse ##1 !pulse))
    else $error("Sense edge not seen once.");
endmodule

// File: fan_model.sv
`timescale 1ns/1ps

// ============================================================================
// Fan and sense network: a spike on each turn-on and commutation pulses.
module fan_model #(
  parameter int unsigned GAP = 40
) (
  input  wire logic i_clk,
  input  wire logic i_drive,
  input  wire logic i_spin,
  output logic      o_sense = 1'b0
);
  int unsigned cnt = 0;
  logic        drive_q = 1'b0;

  // Commutation only happens while the fan is energised, so the count pauses in off-time.
  always @(posedge i_clk) begin
    drive_q <= i_drive;
    if (i_drive && i_spin) begin
      cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
    end
    o_sense <= (i_drive && !drive_q) || (i_drive && i_spin && cnt < 4);
  end
endmodule

// File: fan_pwm_fault_sequencer_bench.sv
`timescale 1ns/1ps

// ============================================================================
// Self-checking bench; the sense pin is fed by the fan model.
module fan_pwm_fault_sequencer_bench;
  localparam int P = 64;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic [7:0] temp_duty = 8'h00;
  logic [7:0] min_duty = 8'h00;
  logic       shutdown = 1'b0;
  logic       spin = 1'b0;
  logic       sense;
  logic       fan_drive;
  logic       fault_n;
  int         n_mismatch = 0;
  int         checks_done = 0;
  int         n;
  int         f;

  // Clock of 8 ns period.
  always #4 clk = ~clk;

  fan_pwm_fault_sequencer #(.PERIOD_CLK(P), .DUTY_W(8), .BLANK_CLK(16)) u_dut (
    .i_core_clk(clk), .i_nrst(nrst), .i_temp_duty(temp_duty), .i_min_duty(min_duty),
    .i_shutdown(shutdown), .i_sense(sense), .o_fan_drive(fan_drive), .o_fault_n(fault_n));

  fan_model u_fan (.i_clk(clk), .i_drive(fan_drive), .i_spin(spin), .o_sense(sense));

  task automatic complete_run();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic near(input int got, input int exp, input int tol);
    checks_done++;
    if (got < exp - tol || got > exp + tol) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Counts drive-high and fault-low clocks over a window.
  task automatic watch(input int win, output int hi, output int lo);
    hi = 0;
    lo = 0;
    repeat (win) begin
      @(negedge clk);
      hi += int'(fan_drive === 1'b1);
      lo += int'(fault_n === 1'b0);
    end
  endtask

  // Waits for a level on drive (sel 0) or the flag (sel 1); a hang ends the run.
  task automatic wait_for(input bit sel, input logic v, input int lim, output int t);
    t = 0;
    while ((sel ? fault_n : fan_drive) !== v) begin
      @(negedge clk);
      t++;
      if (t > lim) begin
        n_mismatch++;
        complete_run();
      end
    end
  endtask

  // Stalled fan from power-up: two boosts back to back, then a latched fault.
  task automatic s_power_stall();
    chk({fan_drive, fault_n}, 2'h1);
    nrst = 1'b1;
    wait_for(0, 1'b1, 10, n);
    wait_for(0, 1'b0, 70 * P, n);
    near(n, 4064, 40);
    watch(2, n, f);
    chk({fan_drive, fault_n}, 2'h0);
  endtask

  // Fault holds at full command; a short shutdown pulse clears it and replays the boost.
  task automatic s_fault_clear();
    temp_duty = 8'hFF;
    watch(10 * P, n, f);
    near(n, 0, 0);
    near(f, 10 * P, 0);
    temp_duty = 8'h00;
    shutdown = 1'b1;
    watch(2, n, f);
    chk({fan_drive, fault_n}, 2'h1);
    shutdown = 1'b0;
    wait_for(0, 1'b1, 10, n);
    watch(20 * P, n, f);
    near(n, 20 * P, 0);
    near(f, 0, 0);
  endtask

  // Duty follows the larger command, across the whole scale.
  task automatic s_duty();
    logic [7:0] tv[4] = '{8'h40, 8'hC0, 8'hFF, 8'h00};
    logic [7:0] mv[4] = '{8'h80, 8'h20, 8'h00, 8'h00};
    int         e[4] = '{32, 48, 64, 0};
    spin = 1'b1;
    watch(50 * P, n, f);
    for (int i = 0; i < 4; i++) begin
      temp_duty = tv[i];
      min_duty = mv[i];
      watch(2 * P, n, f);
      watch(P, n, f);
      near(n, e[i], 2);
    end
  endtask

  // Fan stops in normal running; a pulse during the diagnostic hold brings PWM back.
  task automatic s_diag_recover();
    temp_duty = 8'h80;
    watch(4 * P, n, f);
    spin = 1'b0;
    n = 0;
    f = 0;
    while (f < 40) begin
      @(negedge clk);
      n++;
      f = (fan_drive === 1'b1) ? f + 1 : 0;
      if (n > 3000) begin
        n_mismatch++;
        complete_run();
      end
    end
    near(n, 2000, 160);
    spin = 1'b1;
    watch(4 * P, n, f);
    watch(P, n, f);
    near(n, 32, 3);
    near(f, 0, 0);
  endtask

  // Fan stops for good: timeout, diagnostic, retry boost, then fault.
  task automatic s_stall_fault();
    spin = 1'b0;
    wait_for(1, 1'b0, 5000, n);
    near(n, 4208, 140);
    chk({fan_drive, fault_n}, 2'h0);
  endtask

  // Power cycle out of the latched fault: idle outputs in reset, then the boost replays.
  task automatic s_power_cycle();
    nrst = 1'b0;
    watch(2, n, f);
    chk({fan_drive, fault_n}, 2'h1);
    nrst = 1'b1;
    wait_for(0, 1'b1, 10, n);
    watch(4 * P, n, f);
    near(n, 4 * P, 0);
    near(f, 0, 0);
  endtask

  // Long shutdown at full command: no drive, flag released, no fault judged.
  task automatic s_shutdown_hold();
    temp_duty = 8'hFF;
    shutdown = 1'b1;
    watch(40 * P, n, f);
    near(n, 0, 1);
    near(f, 0, 1);
    shutdown = 1'b0;
  endtask

  initial begin
    repeat (5) @(negedge clk);
    s_power_stall();
    s_fault_clear();
    s_duty();
    s_diag_recover();
    s_stall_fault();
    s_power_cycle();
    s_shutdown_hold();
    complete_run();
  end
endmodule
